// >>> design/mcd_defines.vh
// Constants for the matrix channel command decoder.
// Assumes inclusion by mcd_top.v, mcd_chan_decode.v and the port checker.
`ifndef MCD_DEFINES_VH
`define MCD_DEFINES_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define MCD_OP_CLOSE    4'h0
`define MCD_OP_OPEN     4'h1
`define MCD_OP_QCLOSED  4'h2
`define MCD_OP_QOPEN    4'h3
`define MCD_OP_SETWIRE  4'h4
`define MCD_OP_IDENT    4'h5
`define MCD_OP_CYCLES   4'h6
`define MCD_OP_SLOTRST  4'h7
`define MCD_OP_ILKSIM   4'h8

// ----------------------------------------
// Module type codes on the slot type pins
// ----------------------------------------
`define MCD_TYPE_EMPTY  3'h0
`define MCD_TYPE_ARM8   3'h1
`define MCD_TYPE_ARM16  3'h2
`define MCD_TYPE_CONFIG 3'h3

// ----------------------------------------
// Geometry
// ----------------------------------------
`define MCD_SLOTS       8
`define MCD_LOCS        132
`define MCD_RELAYS      1056
`define MCD_ABUS_BASE   8'h80
`define MCD_LOC_LAST    8'h83
`define MCD_LOC_STRIDE  11'h084
`define MCD_BOOT_DONE   2'h3
`define MCD_BOOT_TAKE   2'h2

// Identity base code, value arbitrary
`define MCD_ID_CODE     12'hA5C

`endif

// >>> design/mcd_chan_decode.v
// Decodes one slot digit and three channel digits into slot and local index.
// Assumes BCD digits and a per-slot wire mode vector (1 = one-wire).
`timescale 1ns/100ps
`include "mcd_defines.vh"

module mcd_chan_decode (
  input  wire [3:0]  slot_bcd,
  input  wire [11:0] chan_bcd,
  input  wire [7:0]  mode_vec,
  output wire        slot_ok,
  output wire [2:0]  slot,
  output reg         chan_ok,
  output reg  [7:0]  loc,
  output reg         abus
);

  wire [3:0] d2;
  wire [3:0] d1;
  wire [3:0] d0;
  wire [4:0] col;
  wire       one_wire;

  assign d2       = chan_bcd[11:8];
  assign d1       = chan_bcd[7:4];
  assign d0       = chan_bcd[3:0];
  assign slot_ok  = (slot_bcd >= 4'h1) && (slot_bcd <= 4'h8); // RULE1
  assign slot     = slot_bcd[2:0] - 3'h1;
  assign one_wire = mode_vec[slot];
  assign col      = {1'b0, d1} * 5'h0A + {1'b0, d0};

  // ----------------------------------------
  // Channel split per wire mode
  // ----------------------------------------
  always @* begin
    chan_ok = 1'b0;
    loc     = 8'h00;
    abus    = 1'b0;
    if (d2 == 4'h9) begin
      // Bus relays sit above every crosspoint so ascending order holds
      abus    = (d1 == 4'h2) && (d0 >= 4'h1) && (d0 <= 4'h4); // RULE7 RULE8
      chan_ok = abus;
      loc     = `MCD_ABUS_BASE + {6'h00, d0[1:0] - 2'h1};
    end else if (one_wire) begin
      // Matrix, row, column
      chan_ok = (d2 >= 4'h1) && (d2 <= 4'h4) && (d1 >= 4'h1) && (d1 <= 4'h4)
                && (d0 >= 4'h1) && (d0 <= 4'h8); // RULE3
      loc     = {1'b0, d2[1:0] - 2'h1, d1[1:0] - 2'h1, d0[2:0] - 3'h1};
    end else begin
      // Row, two-digit column
      chan_ok = (d2 >= 4'h1) && (d2 <= 4'h8) && (col >= 5'h01) && (col <= 5'h10)
                && (d1 <= 4'h1) && (d0 <= 4'h9); // RULE2
      loc     = {1'b0, d2[2:0] - 3'h1, col[3:0] - 4'h1};
    end
    chan_ok = chan_ok && slot_ok;
  end

endmodule // mcd_chan_decode

// >>> design/mcd_top.v
// Command engine for up to eight relay matrix modules in a mainframe.
// Assumes slot type, interlock and boot wire-mode pins are asynchronous
// and that a nonvolatile store returns nv_wire_mode_out as nv_wire_mode_in
// after the next power cycle (rst).
//
// Behaviour
// RULE1: address is slot digit plus three digits
// RULE2: two-wire splits row, two-digit column
// RULE3: one-wire splits matrix, row, column
// RULE4: range expansion skips analog bus relays
// RULE5: bus relay as range endpoint errors
// RULE6: ranges walk across slots
// RULE7: two-wire bus relays 921-924 serve matrix two
// RULE8: one-wire bus reaches only matrices three, four
// RULE9: closed query 1/0, open query inverse
// RULE10: wire mode on fixed module errors
// RULE11: wire mode waits for power cycle
// RULE12: identity carries single-ended suffix flag
// RULE13: per-relay cycle counts, readable per channel
// RULE14: slot reset clears only that slot
// RULE15: slots operate independently, numbering unchanged
// RULE16: bus close without interlock errors, stays open
// RULE17: simulation hides error, relays stay open
// RULE18: out-of-configuration channel errors, no change
// RULE19: ascending walk, list items in order
`timescale 1ns/100ps
`include "mcd_defines.vh"

module mcd_top (
  input  wire          core_clk,
  input  wire          rst,
  input  wire          cmd_valid,
  output wire          cmd_ready,
  input  wire [3:0]    cmd_op,
  input  wire          cmd_range,
  input  wire [3:0]    cmd_slot_a,
  input  wire [11:0]   cmd_chan_a,
  input  wire [3:0]    cmd_slot_b,
  input  wire [11:0]   cmd_chan_b,
  input  wire          cmd_value,
  input  wire [23:0]   slot_type_pin,
  input  wire [7:0]    interlock_pin,
  input  wire [7:0]    nv_wire_mode_in,
  output wire [7:0]    nv_wire_mode_out,
  output wire [1055:0] relay_state,
  output wire          rsp_valid,
  output wire          rsp_err,
  output wire [15:0]   rsp_data
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WALK = 1'b1;

  reg  [23:0]   type_s1_q, type_s2_q;
  reg  [7:0]    ilk_s1_q, ilk_s2_q;
  reg  [7:0]    nvm_s1_q, nvm_s2_q;
  reg  [1:0]    boot_q;
  reg  [7:0]    mode_q;
  reg  [7:0]    pend_q;
  reg           ilk_sim_q;
  reg           state_q;
  reg           tgt_q, single_q;
  reg  [2:0]    ws_q, es_q;
  reg  [7:0]    wl_q, el_q;
  reg  [1055:0] relay_q;
  reg  [15:0]   cyc_q [0:1055];
  reg           rsp_valid_q, rsp_err_q;
  reg  [15:0]   rsp_data_q;

  wire          a_sok, a_ok, a_abus, b_ok, b_abus;
  wire [2:0]    a_slot, b_slot;
  wire [7:0]    a_loc, b_loc;
  wire [2:0]    a_type, w_type;
  wire          a_valid, b_valid;
  wire [10:0]   a_g, w_g;
  integer       i;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [2:0] type_of;
    input [23:0] v;
    input [2:0]  s;
    begin
      type_of = v[s*3 +: 3];
    end
  endfunction

  // Crosspoint exists in the module's present configuration
  function loc_valid;
    input [2:0] t;
    input       one_wire;
    input [7:0] l;
    begin
      case (t)
        `MCD_TYPE_ARM8:   loc_valid = (l >= `MCD_ABUS_BASE) || !l[3];
        `MCD_TYPE_ARM16:  loc_valid = 1'b1;
        `MCD_TYPE_CONFIG: loc_valid = one_wire || (l >= `MCD_ABUS_BASE) || !l[3];
        default:          loc_valid = 1'b0;
      endcase
      loc_valid = loc_valid && (l <= `MCD_LOC_LAST);
    end
  endfunction

  function [10:0] gidx;
    input [2:0] s;
    input [7:0] l;
    begin
      gidx = {8'h00, s} * `MCD_LOC_STRIDE + {3'h0, l}; // RULE15
    end
  endfunction

  mcd_chan_decode u_dec_a (
    .slot_bcd (cmd_slot_a),
    .chan_bcd (cmd_chan_a),
    .mode_vec (mode_q),
    .slot_ok  (a_sok),
    .slot     (a_slot),
    .chan_ok  (a_ok),
    .loc      (a_loc),
    .abus     (a_abus)
  );

  mcd_chan_decode u_dec_b (
    .slot_bcd (cmd_slot_b),
    .chan_bcd (cmd_chan_b),
    .mode_vec (mode_q),
    .slot_ok  (),
    .slot     (b_slot),
    .chan_ok  (b_ok),
    .loc      (b_loc),
    .abus     (b_abus)
  );

  assign a_type  = type_of(type_s2_q, a_slot);
  assign w_type  = type_of(type_s2_q, ws_q);
  assign a_valid = a_ok && loc_valid(a_type, mode_q[a_slot], a_loc); // RULE18
  assign b_valid = b_ok && loc_valid(type_of(type_s2_q, b_slot), mode_q[b_slot], b_loc);
  assign a_g     = gidx(a_slot, a_loc);
  assign w_g     = gidx(ws_q, wl_q);

  // One item at a time keeps list order
  assign cmd_ready        = (state_q == ST_IDLE) && (boot_q == `MCD_BOOT_DONE); // RULE19
  assign nv_wire_mode_out = pend_q;
  assign relay_state      = relay_q;
  assign rsp_valid        = rsp_valid_q;
  assign rsp_err          = rsp_err_q;
  assign rsp_data         = rsp_data_q;

  // ----------------------------------------
  // Pin synchronisers and boot capture
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      type_s1_q <= 24'h000000;
      type_s2_q <= 24'h000000;
      ilk_s1_q  <= 8'h00;
      ilk_s2_q  <= 8'h00;
      nvm_s1_q  <= 8'h00;
      nvm_s2_q  <= 8'h00;
      boot_q    <= 2'h0;
    end else begin
      type_s1_q <= slot_type_pin;
      type_s2_q <= type_s1_q;
      ilk_s1_q  <= interlock_pin;
      ilk_s2_q  <= ilk_s1_q;
      nvm_s1_q  <= nv_wire_mode_in;
      nvm_s2_q  <= nvm_s1_q;
      if (boot_q != `MCD_BOOT_DONE)
        boot_q <= boot_q + 2'h1;
    end
  end

  // ----------------------------------------
  // Command engine
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q      <= 8'h00;
      pend_q      <= 8'h00;
      ilk_sim_q   <= 1'b0;
      state_q     <= ST_IDLE;
      tgt_q       <= 1'b0;
      single_q    <= 1'b0;
      ws_q        <= 3'h0;
      es_q        <= 3'h0;
      wl_q        <= 8'h00;
      el_q        <= 8'h00;
      relay_q     <= {`MCD_RELAYS{1'b0}};
      rsp_valid_q <= 1'b0;
      rsp_err_q   <= 1'b0;
      rsp_data_q  <= 16'h0000;
      for (i = 0; i < `MCD_RELAYS; i = i + 1)
        cyc_q[i] <= 16'h0000;
    end else begin
      rsp_valid_q <= 1'b0;
      // Wire mode only takes effect here, after a power cycle
      if (boot_q == `MCD_BOOT_TAKE) begin
        mode_q <= nvm_s2_q; // RULE11
        pend_q <= nvm_s2_q;
      end
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            rsp_valid_q <= 1'b1;
            rsp_err_q   <= 1'b0;
            rsp_data_q  <= 16'h0000;
            case (cmd_op)
              `MCD_OP_CLOSE, `MCD_OP_OPEN: begin
                tgt_q    <= (cmd_op == `MCD_OP_CLOSE);
                single_q <= !cmd_range;
                ws_q     <= a_slot;
                wl_q     <= a_loc;
                es_q     <= cmd_range ? b_slot : a_slot;
                el_q     <= cmd_range ? b_loc : a_loc;
                if (!a_valid || (cmd_range && !b_valid)) begin
                  rsp_err_q <= 1'b1; // RULE18
                end else if (cmd_range && (a_abus || b_abus)) begin
                  rsp_err_q <= 1'b1; // RULE5
                end else if (cmd_range && ({a_slot, a_loc} > {b_slot, b_loc})) begin
                  rsp_err_q <= 1'b1;
                end else if (a_abus && (cmd_op == `MCD_OP_CLOSE) && !ilk_s2_q[a_slot]) begin
                  rsp_err_q <= !ilk_sim_q; // RULE16 RULE17
                end else begin
                  rsp_valid_q <= 1'b0;
                  state_q     <= ST_WALK;
                end
              end
              `MCD_OP_QCLOSED, `MCD_OP_QOPEN: begin
                rsp_err_q  <= !a_valid;
                rsp_data_q <= {15'h0000,
                               relay_q[a_g] ^ (cmd_op == `MCD_OP_QOPEN)}; // RULE9
              end
              `MCD_OP_SETWIRE: begin
                if (a_sok && (a_type == `MCD_TYPE_CONFIG))
                  pend_q[a_slot] <= cmd_value;
                else
                  rsp_err_q <= 1'b1; // RULE10
              end
              `MCD_OP_IDENT: begin
                rsp_err_q  <= !a_sok || (a_type == `MCD_TYPE_EMPTY);
                rsp_data_q <= {(a_type == `MCD_TYPE_CONFIG) && mode_q[a_slot],
                               a_type, `MCD_ID_CODE}; // RULE12
              end
              `MCD_OP_CYCLES: begin
                rsp_err_q  <= !a_valid;
                rsp_data_q <= cyc_q[a_g]; // RULE13
              end
              `MCD_OP_SLOTRST: begin
                if (a_sok && (a_type != `MCD_TYPE_EMPTY))
                  relay_q[a_g - {3'h0, a_loc} +: `MCD_LOCS] <= {`MCD_LOCS{1'b0}}; // RULE14
                else
                  rsp_err_q <= 1'b1;
              end
              `MCD_OP_ILKSIM: ilk_sim_q <= cmd_value;
              default:        rsp_err_q <= 1'b1;
            endcase
          end
        end
        ST_WALK: begin
          // Ascending walk; bus relays only touched when named alone
          if (loc_valid(w_type, mode_q[ws_q], wl_q)
              && (single_q || (wl_q < `MCD_ABUS_BASE))) begin // RULE4 RULE6
            if (relay_q[w_g] != tgt_q) begin
              relay_q[w_g] <= tgt_q;
              cyc_q[w_g]   <= cyc_q[w_g] + 16'h0001; // RULE13
            end
          end
          if ((ws_q == es_q) && (wl_q == el_q)) begin
            state_q     <= ST_IDLE;
            rsp_valid_q <= 1'b1;
            rsp_err_q   <= 1'b0;
            rsp_data_q  <= 16'h0000;
          end else if (wl_q == `MCD_LOC_LAST) begin
            ws_q <= ws_q + 3'h1; // RULE6
            wl_q <= 8'h00;
          end else begin
            wl_q <= wl_q + 8'h01; // RULE19
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      // Lost interlock opens the slot's bus relays at once
      for (i = 0; i < `MCD_SLOTS; i = i + 1)
        if (!ilk_s2_q[i])
          relay_q[i*`MCD_LOCS + 128 +: 4] <= 4'h0; // RULE16 RULE17
    end
  end

endmodule // mcd_top

// >>> verif/mcd_host_model.sv
// Host model: issues one command at a time on the request handshake.
// Assumes a single calling process and the engine's one-request rule.
`timescale 1ns/100ps

module mcd_host_model (
  input  wire         core_clk,
  input  wire         cmd_ready,
  input  wire         rsp_valid,
  input  wire         rsp_err,
  input  wire  [15:0] rsp_data,
  output logic        cmd_valid,
  output logic [3:0]  cmd_op,
  output logic        cmd_range,
  output logic [15:0] addr_a,
  output logic [15:0] addr_b,
  output logic        cmd_value
);
  int          lat;
  logic        err;
  logic [15:0] data;

  initial {cmd_valid, cmd_op, cmd_range, addr_a, addr_b, cmd_value} = '0;

  // List items go one by one, in call order
  task send(input [3:0] op, input rng, input [15:0] a, b, input v);
    @(negedge core_clk);
    {cmd_op, cmd_range, addr_a, addr_b, cmd_value} = {op, rng, a, b, v};
    cmd_valid = 1'b1;
    while (!cmd_ready) @(negedge core_clk);
    @(posedge core_clk);
    lat = 0;
    // Answer judged at falling edges, where the one-cycle pulse is settled
    do begin
      @(negedge core_clk);
      if (lat == 0) begin
        cmd_valid = 1'b0;
        // Stale op and address fields inverted so the engine cannot lean on them
        {cmd_op, addr_a, addr_b} = ~{cmd_op, addr_a, addr_b};
      end
      lat++;
    end while (!rsp_valid && lat < 1200);
    err = rsp_err;
    data = rsp_data;
  endtask
endmodule // mcd_host_model

// >>> verif/mcd_monitor.sv
// Checker on the command engine ports.
// Assumes it is bound into every engine instance.
`timescale 1ns/100ps
`include "mcd_defines.vh"

module mcd_monitor (
  input wire          core_clk,
  input wire          rst,
  input wire          cmd_valid,
  input wire          cmd_ready,
  input wire [3:0]    cmd_op,
  input wire          cmd_range,
  input wire [7:0]    interlock_pin,
  input wire [7:0]    nv_wire_mode_out,
  input wire [1055:0] relay_state,
  input wire          rsp_valid,
  input wire          rsp_err,
  input wire [15:0]   rsp_data
);
  wire        take  = cmd_valid && cmd_ready;
  wire        quick = take && (cmd_op inside {4'h2, 4'h3, 4'h5, 4'h6});
  wire        walk  = take && cmd_op <= `MCD_OP_OPEN;
  logic [10:0] wait_q;

  // Full-span range needs 1057 edges, too long for a delay range
  always @(posedge core_clk or posedge rst) begin
    if (rst) wait_q <= 11'h000;
    else if (rsp_valid) wait_q <= 11'h000;
    else if (take || wait_q != 11'h000) wait_q <= wait_q + 11'h001;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_QUERY_LAT: assert property (quick |=> rsp_valid)
    else $error("query answer late");
  AST_QUERY_HOLD: assert property (quick |=> $stable(relay_state))
    else $error("query moved relays");
  AST_WALK_BUSY: assert property (walk |=> !cmd_ready || rsp_valid)
    else $error("request accepted during walk");
  AST_SINGLE_LAT: assert property (walk && !cmd_range |-> ##[1:2] rsp_valid)
    else $error("single channel answer late");
  AST_WALK_BOUND: assert property (wait_q <= 11'h422)
    else $error("range walk too long");
  AST_BAD_OP: assert property (take && cmd_op > `MCD_OP_ILKSIM |=> rsp_valid && rsp_err)
    else $error("unknown op accepted");
  AST_IDENT: assert property (take && cmd_op == `MCD_OP_IDENT |=>
    rsp_err || rsp_data[11:0] == `MCD_ID_CODE) else $error("identity code wrong");
  AST_NV_HOLD: assert property ($changed(nv_wire_mode_out) && $past(cmd_ready, 2) |->
    $past(take && cmd_op == `MCD_OP_SETWIRE) || $past(take && cmd_op == `MCD_OP_SETWIRE, 2))
    else $error("pending mode moved without command");
  AST_ILK_OPEN: assert property ((!interlock_pin[1])[*4] |-> relay_state[263:260] == 4'h0)
    else $error("bus relay closed without interlock");

  cover property (walk && cmd_range);
  cover property (rsp_valid && rsp_err);
  cover property (take && cmd_op == `MCD_OP_SETWIRE);
endmodule // mcd_monitor

bind mcd_top mcd_monitor u_mcd_monitor (.core_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op,
  .cmd_range, .interlock_pin, .nv_wire_mode_out, .relay_state, .rsp_valid, .rsp_err, .rsp_data);

// >>> verif/tb_top.sv
// Self-checking bench for the command engine.
// Assumes the host model drives commands; the bench plays slots and store.
`timescale 1ns/100ps

module tb_top;
  logic          core_clk = 1'b0;
  logic          rst = 1'b1;
  logic [7:0]    nv_q = 8'h00;
  logic [7:0]    ilk_q = 8'hFD;
  int            errors = 0;
  int            samples_checked = 0;
  int            cycles = 0;
  wire           cmd_valid, cmd_ready, cmd_range, cmd_value, rsp_valid, rsp_err;
  wire  [3:0]    cmd_op;
  wire  [15:0]   a_w, b_w, rsp_data;
  wire  [7:0]    nv_wire_mode_out;
  wire  [1055:0] relay_state;

  always #10 core_clk = ~core_clk;

  mcd_top u_mcd_top (.core_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_range,
    .cmd_slot_a(a_w[15:12]), .cmd_chan_a(a_w[11:0]), .cmd_slot_b(b_w[15:12]),
    .cmd_chan_b(b_w[11:0]), .cmd_value, .slot_type_pin(24'h2490D1),
    .interlock_pin(ilk_q), .nv_wire_mode_in(nv_q), .nv_wire_mode_out, .relay_state,
    .rsp_valid, .rsp_err, .rsp_data);

  mcd_host_model u_mcd_host_model (.core_clk, .cmd_ready, .rsp_valid, .rsp_err,
    .rsp_data, .cmd_valid, .cmd_op, .cmd_range, .addr_a(a_w), .addr_b(b_w), .cmd_value);

  task chk(input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Store hands pending mode back after the power cycle
  task power_cycle;
    @(negedge core_clk);
    nv_q = nv_wire_mode_out;
    rst = 1'b1;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
  endtask

  function logic rl(input int s, l);
    return relay_state[(s - 1) * 132 + l];
  endfunction

  task cmd(input [3:0] op, input rng, input [15:0] a, b, input v, input int el, input ee);
    u_mcd_host_model.send(op, rng, a, b, v);
    if (el > 0) chk(16'(u_mcd_host_model.lat), 16'(el));
    chk(16'(u_mcd_host_model.err), 16'(ee));
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_decode;
    cmd(4'h0, 0, 16'h1304, 0, 0, 2, 0);
    chk(rl(1, 35), 1);
    cmd(4'h2, 0, 16'h1304, 0, 0, 1, 0);
    chk(rsp_data[0], 1);
    cmd(4'h3, 0, 16'h1304, 0, 0, 1, 0);
    chk(rsp_data[0], 0);
    cmd(4'h0, 0, 16'h2315, 0, 0, 2, 0);
    chk(rl(2, 46), 1);
    cmd(4'h0, 0, 16'h1315, 0, 0, 1, 1);
    chk(rl(1, 46), 0);
    cmd(4'h0, 0, 16'h4101, 0, 0, 1, 1);
    cmd(4'h0, 0, 16'h9304, 0, 0, 1, 1);
    cmd(4'hF, 0, 16'h1304, 0, 0, 1, 1);
  endtask

  task t_range;
    cmd(4'h0, 1, 16'h1801, 16'h2101, 0, 22, 0);
    chk(relay_state[119:112], 16'h00FF);
    chk(relay_state[131:120], 16'h0000);
    chk(rl(2, 0), 1);
    cmd(4'h0, 1, 16'h1921, 16'h2101, 0, 1, 1);
    chk(rl(1, 128), 0);
    cmd(4'h1, 1, 16'h1801, 16'h1808, 0, 9, 0);
    chk(relay_state[119:112], 16'h0000);
  endtask

  task t_bus;
    cmd(4'h0, 0, 16'h1921, 0, 0, 2, 0);
    chk(rl(1, 128), 1);
    // Continuity lost while closed: relay must drop after the synchroniser
    @(negedge core_clk);
    ilk_q = 8'hFC;
    repeat (4) @(negedge core_clk);
    chk(rl(1, 128), 0);
    ilk_q = 8'hFD;
    cmd(4'h0, 0, 16'h2921, 0, 0, 1, 1);
    chk(rl(2, 128), 0);
    cmd(4'h8, 0, 16'h2000, 0, 1, 1, 0);
    cmd(4'h0, 0, 16'h2922, 0, 0, 1, 0);
    chk(rl(2, 129), 0);
    cmd(4'h8, 0, 16'h2000, 0, 0, 1, 0);
  endtask

  task t_count;
    cmd(4'h6, 0, 16'h1304, 0, 0, 1, 0);
    chk(rsp_data, 16'h0001);
    cmd(4'h1, 0, 16'h1304, 0, 0, 2, 0);
    cmd(4'h0, 0, 16'h1101, 0, 0, 2, 0);
    chk(rl(1, 0), 1);
    cmd(4'h7, 0, 16'h1000, 0, 0, 1, 0);
    chk(|relay_state[131:0], 0);
    chk(rl(2, 0), 1);
    cmd(4'h6, 0, 16'h1304, 0, 0, 1, 0);
    chk(rsp_data, 16'h0002);
  endtask

  task t_wire;
    cmd(4'h4, 0, 16'h1000, 0, 1, 1, 1);
    cmd(4'h4, 0, 16'h3000, 0, 1, 1, 0);
    chk(nv_wire_mode_out, 16'h0004);
    cmd(4'h5, 0, 16'h3000, 0, 0, 1, 0);
    chk(rsp_data, 16'h3A5C);
    cmd(4'h0, 0, 16'h3437, 0, 0, 1, 1);
    power_cycle;
    cmd(4'h5, 0, 16'h3000, 0, 0, 1, 0);
    chk(rsp_data, 16'hBA5C);
    cmd(4'h0, 0, 16'h3437, 0, 0, 2, 0);
    chk(rl(3, 118), 1);
    cmd(4'h0, 0, 16'h3921, 0, 0, 2, 0);
    chk(rl(3, 128), 1);
    cmd(4'h4, 0, 16'h3000, 0, 0, 1, 0);
    chk(nv_wire_mode_out, 16'h0000);
    cmd(4'h5, 0, 16'h3000, 0, 0, 1, 0);
    chk(rsp_data, 16'hBA5C);
    cmd(4'h5, 0, 16'h4000, 0, 0, 1, 1);
  endtask

  // Ceiling well above the hundred or so cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    power_cycle;
    t_decode;
    t_range;
    t_bus;
    t_count;
    t_wire;
    give_verdict();
  end
endmodule // tb_top
